// >>> rtl/cpu_slice_defines.svh
`ifndef CPU_SLICE_DEFINES_SVH
`define CPU_SLICE_DEFINES_SVH

// ==========================================================================
// opcodes
`define OP_SET_CARRY    8'h99
`define OP_SET_MASK     8'h9b
`define OP_STOP         8'h8e
`define OP_IRET         8'h80

// low nibble selects the operation, high nibble the addressing mode
`define LO_SUB          4'h0
`define LO_STA          4'h7
`define LO_STX          4'hf
`define HI_IMM          4'ha
`define HI_DIR          4'hb
`define HI_EXT          4'hc
`define HI_IX2          4'hd
`define HI_IX1          4'he
`define HI_IX0          4'hf

// ==========================================================================
// instruction cycle counts
`define CYC_INH         5'd2
`define CYC_IRET        5'd9
`define CYC_STORE_EXTRA 5'd1
`define CYC_SUB_IMM     5'd2
`define CYC_SUB_DIR_H   5'd4
`define CYC_SUB_DIR_C   5'd3
`define CYC_SUB_EXT_H   5'd5
`define CYC_SUB_EXT_C   5'd4
`define CYC_SUB_IX0_H   5'd4
`define CYC_SUB_IX0_C   5'd3
`define CYC_SUB_IX1_H   5'd5
`define CYC_SUB_IX1_C   5'd4
`define CYC_SUB_IX2_H   5'd6
`define CYC_SUB_IX2_C   5'd5
`define WAKE_CYCLES     1920

// ==========================================================================
// flag register bit positions
`define CC_H            4
`define CC_I            3
`define CC_N            2
`define CC_Z            1
`define CC_C            0
`define CC_STACK_ONES   3'b111

// ==========================================================================
// reset values and vectors
`define CC_RESET        5'h08
`define SP_RESET        16'h007f
`define ACC_RESET       8'h00
`define PTR_RESET       8'h00
`define RST_VECTOR      16'hfffe
`define IRQ_VECTOR      16'hfffa

`endif

// >>> rtl/cpu_slice_pkg.sv
package cpu_slice_pkg;

    // ======================================================================
    // decode types
    typedef enum logic [2:0] {
        CL_NONE, CL_SEC, CL_SEI, CL_STA, CL_STX, CL_SUB, CL_STOP, CL_IRET
    } op_class_t;

    typedef enum logic [2:0] {
        AM_INH, AM_IMM, AM_DIR, AM_EXT, AM_IX0, AM_IX1, AM_IX2
    } addr_mode_t;

    typedef enum logic [3:0] {
        S_FETCH, S_OPND1, S_OPND2, S_READ, S_WRITE, S_EXEC, S_PAD,
        S_PUSH, S_PULL, S_VHI, S_VLO, S_STOP, S_WAKE
    } core_state_t;

    // ======================================================================
    // carriers
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } mem_req_t;

    typedef struct packed {
        logic tmr_presc_clr;
        logic tmr_irq_dis;
        logic tmr_flag_clr;
    } stop_pulse_t;

    typedef struct packed {
        core_state_t st;
        logic [15:0] pc;
        logic [7:0]  acc;
        logic [7:0]  ptr;
        logic [4:0]  cc;
        logic [15:0] sp;
        logic [7:0]  op;
        logic [7:0]  b1;
        logic [15:0] ea;
        logic [4:0]  left;
        logic [2:0]  k;
        logic [11:0] wake;
        logic [15:0] vec;
        mem_req_t    req;
        stop_pulse_t pulse;
        logic        osc_en;
        logic [2:0]  irq_sync;
        logic        irq_act;
    } core_t;

endpackage

// >>> rtl/flag_unit.sv
`timescale 1ns/1ps
`include "cpu_slice_defines.svh"

module flag_unit (
    // operation
    input  wire cpu_slice_pkg::op_class_t cls,
    // operands
    input  wire logic [7:0]               acc,
    input  wire logic [7:0]               ptr,
    input  wire logic [7:0]               data,
    input  wire logic [4:0]               cc_in,
    // results
    output logic [7:0]                    result,
    output logic [4:0]                    cc_out
);
    import cpu_slice_pkg::*;

    logic [8:0] diff;

    always_comb begin
        diff   = {1'b0, acc} - {1'b0, data};
        result = acc;
        cc_out = cc_in;
        case (cls)
            // RQ1: carry forced
            CL_SEC: cc_out[`CC_C] = 1'b1;
            // RQ2: mask forced
            CL_SEI: cc_out[`CC_I] = 1'b1;
            // RQ15: mask cleared
            CL_STOP: cc_out[`CC_I] = 1'b0;
            // RQ5: flags from accumulator
            CL_STA: begin
                cc_out[`CC_N] = acc[7];
                cc_out[`CC_Z] = (acc == 8'h00);
            end
            // RQ8: flags from pointer
            CL_STX: begin
                cc_out[`CC_N] = ptr[7];
                cc_out[`CC_Z] = (ptr == 8'h00);
            end
            CL_SUB: begin
                // RQ10: no incoming carry
                result        = diff[7:0];
                // RQ11: borrow into carry
                cc_out[`CC_N] = diff[7];
                cc_out[`CC_Z] = (diff[7:0] == 8'h00);
                cc_out[`CC_C] = diff[8];
            end
            default: cc_out = cc_in;
        endcase
    end

endmodule // flag_unit

// >>> rtl/cpu_set_store_sub_stop_ops.sv
// Notes on behaviour
// RQ1: set-carry 99 forces carry, other flags kept, two cycles.
// RQ2: set-mask 9B forces interrupt mask, other flags kept, two cycles.
// RQ3: with mask set, interrupts are not taken; program runs on.
// RQ4: store-accumulator writes accumulator to memory, accumulator kept.
// RQ5: store-accumulator sets negative and zero from accumulator; others kept.
// RQ6: store-accumulator opcodes B7/C7/F7/E7/D7 with their byte and cycle counts.
// RQ7: store-pointer writes pointer register to memory, pointer kept.
// RQ8: store-pointer sets negative and zero from pointer register; others kept.
// RQ9: store-pointer opcodes BF/CF/FF/EF/DF with their byte and cycle counts.
// RQ10: subtract puts accumulator minus operand, no carry in, into accumulator.
// RQ11: subtract sets negative, zero and borrow carry; half carry, mask kept.
// RQ12: subtract opcodes A0/B0/C0/F0/E0/D0 with their byte and cycle counts.
// RQ13: stop clears prescaler, timer irq and flag, enables irq, halts oscillator.
// RQ14: low interrupt in stop restarts oscillator, waits 1920 cycles, then vectors.
// RQ15: stop is 8E, two cycles, low-power variant only, clears mask.
// RQ16: after wake-up, external interrupts return with the interrupt-return.
// RQ17: flags H,I,N,Z,C in bits 4..0; upper three stack as ones.
// RQ18: operand address formed from direct, extended or pointer-indexed mode.
`timescale 1ns/1ps
`include "cpu_slice_defines.svh"

module cpu_set_store_sub_stop_ops #(
    parameter bit          CMOS        = 1'b1,
    parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES,
    parameter logic [15:0] RST_VECTOR  = `RST_VECTOR,
    parameter logic [15:0] IRQ_VECTOR  = `IRQ_VECTOR
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    // external interrupt pin
    input  wire logic                   irq_n,
    // memory bus
    input  wire logic [7:0]             mem_rdata,
    output cpu_slice_pkg::mem_req_t     mem_req,
    // timer and oscillator control
    output cpu_slice_pkg::stop_pulse_t  stop_pulse,
    output logic                        osc_en,
    // visible core state
    output logic [7:0]                  accumulator,
    output logic [7:0]                  pointer,
    output logic [4:0]                  flag_register
);
    import cpu_slice_pkg::*;

    // ======================================================================
    // decode functions
    function automatic op_class_t decode_class(input logic [7:0] op);
        decode_class = CL_NONE;
        case (op)
            `OP_SET_CARRY: decode_class = CL_SEC;
            `OP_SET_MASK:  decode_class = CL_SEI;
            `OP_IRET:      decode_class = CL_IRET;
            // RQ15: stop only on low-power build
            `OP_STOP:      decode_class = CMOS ? CL_STOP : CL_NONE;
            default: begin
                if (op[7:4] >= `HI_IMM) begin
                    case (op[3:0])
                        `LO_SUB: decode_class = CL_SUB;
                        `LO_STA: decode_class = (op[7:4] == `HI_IMM) ? CL_NONE : CL_STA;
                        `LO_STX: decode_class = (op[7:4] == `HI_IMM) ? CL_NONE : CL_STX;
                        default: decode_class = CL_NONE;
                    endcase
                end
            end
        endcase
    endfunction

    function automatic addr_mode_t decode_mode(input logic [7:0] op);
        case (op[7:4])
            `HI_IMM: decode_mode = AM_IMM;
            `HI_DIR: decode_mode = AM_DIR;
            `HI_EXT: decode_mode = AM_EXT;
            `HI_IX2: decode_mode = AM_IX2;
            `HI_IX1: decode_mode = AM_IX1;
            `HI_IX0: decode_mode = AM_IX0;
            default: decode_mode = AM_INH;
        endcase
    endfunction

    function automatic logic [1:0] opnd_bytes(input addr_mode_t m);
        case (m)
            AM_IMM, AM_DIR, AM_IX1: opnd_bytes = 2'd1;
            AM_EXT, AM_IX2:         opnd_bytes = 2'd2;
            default:                opnd_bytes = 2'd0;
        endcase
    endfunction

    function automatic logic [4:0] sub_cycles(input addr_mode_t m);
        case (m)
            AM_IMM:  sub_cycles = `CYC_SUB_IMM;
            AM_DIR:  sub_cycles = CMOS ? `CYC_SUB_DIR_C : `CYC_SUB_DIR_H;
            AM_EXT:  sub_cycles = CMOS ? `CYC_SUB_EXT_C : `CYC_SUB_EXT_H;
            AM_IX0:  sub_cycles = CMOS ? `CYC_SUB_IX0_C : `CYC_SUB_IX0_H;
            AM_IX1:  sub_cycles = CMOS ? `CYC_SUB_IX1_C : `CYC_SUB_IX1_H;
            AM_IX2:  sub_cycles = CMOS ? `CYC_SUB_IX2_C : `CYC_SUB_IX2_H;
            default: sub_cycles = `CYC_INH;
        endcase
    endfunction

    // stores take one cycle more than the subtract of the same mode
    function automatic logic [4:0] instr_cycles(input logic [7:0] op);
        case (decode_class(op))
            // RQ6: store-accumulator timing
            CL_STA:  instr_cycles = sub_cycles(decode_mode(op)) + `CYC_STORE_EXTRA;
            // RQ9: store-pointer timing
            CL_STX:  instr_cycles = sub_cycles(decode_mode(op)) + `CYC_STORE_EXTRA;
            // RQ12: subtract timing
            CL_SUB:  instr_cycles = sub_cycles(decode_mode(op));
            CL_IRET: instr_cycles = `CYC_IRET;
            default: instr_cycles = `CYC_INH;
        endcase
    endfunction

    // ======================================================================
    // state
    core_t      r_q;
    core_t      r_d;
    op_class_t  cls_cur;
    addr_mode_t mode_cur;
    logic [7:0] fu_res;
    logic [4:0] fu_cc;

    assign cls_cur  = decode_class(r_q.op);
    assign mode_cur = decode_mode(r_q.op);

    flag_unit u_flags (
        .cls    (cls_cur),
        .acc    (r_q.acc),
        .ptr    (r_q.ptr),
        .data   (mem_rdata),
        .cc_in  (r_q.cc),
        .result (fu_res),
        .cc_out (fu_cc)
    );

    // ======================================================================
    // next state
    always_comb begin
        logic       done;
        logic       end_instr;
        op_class_t  fcls;
        addr_mode_t fmode;
        op_class_t  ncls;
        done      = 1'b0;
        end_instr = 1'b0;
        fcls      = decode_class(mem_rdata);
        fmode     = decode_mode(mem_rdata);
        r_d       = r_q;
        r_d.pulse = '0;
        ncls      = CL_NONE;

        // three-stage pin synchroniser; change accepted when stages 2 and 3 agree
        r_d.irq_sync = {r_q.irq_sync[1:0], irq_n};
        if (r_q.irq_sync[1] == r_q.irq_sync[2]) begin
            r_d.irq_act = ~r_q.irq_sync[2];
        end

        if (r_q.st != S_FETCH && r_q.left != 5'd0) begin
            r_d.left = r_q.left - 5'd1;
        end

        case (r_q.st)
            S_FETCH: begin
                r_d.op   = mem_rdata;
                r_d.pc   = r_q.pc + 16'd1;
                r_d.left = instr_cycles(mem_rdata) - 5'd1;
                case (fcls)
                    CL_STA, CL_STX, CL_SUB: begin
                        if (opnd_bytes(fmode) != 2'd0) begin
                            r_d.st = S_OPND1;
                        end else begin
                            // RQ18: indexed, no offset
                            r_d.ea = {8'h00, r_q.ptr};
                            r_d.st = (fcls == CL_SUB) ? S_READ : S_WRITE;
                        end
                    end
                    default: r_d.st = S_EXEC;
                endcase
            end
            S_OPND1: begin
                r_d.b1 = mem_rdata;
                r_d.pc = r_q.pc + 16'd1;
                if (mode_cur == AM_IMM) begin
                    r_d.acc = fu_res;
                    r_d.cc  = fu_cc;
                    done    = 1'b1;
                end else if (opnd_bytes(mode_cur) == 2'd2) begin
                    r_d.st = S_OPND2;
                end else begin
                    // RQ18: direct page or 8-bit offset
                    if (mode_cur == AM_DIR) begin
                        r_d.ea = {8'h00, mem_rdata};
                    end else begin
                        r_d.ea = {8'h00, mem_rdata} + {8'h00, r_q.ptr};
                    end
                    r_d.st = (cls_cur == CL_SUB) ? S_READ : S_WRITE;
                end
            end
            S_OPND2: begin
                r_d.pc = r_q.pc + 16'd1;
                // RQ18: extended or 16-bit offset
                if (mode_cur == AM_IX2) begin
                    r_d.ea = {r_q.b1, mem_rdata} + {8'h00, r_q.ptr};
                end else begin
                    r_d.ea = {r_q.b1, mem_rdata};
                end
                r_d.st = (cls_cur == CL_SUB) ? S_READ : S_WRITE;
            end
            S_READ: begin
                // RQ10: result back to accumulator
                r_d.acc = fu_res;
                r_d.cc  = fu_cc;
                done    = 1'b1;
            end
            S_WRITE: begin
                r_d.cc = fu_cc;
                done   = 1'b1;
            end
            S_EXEC: begin
                case (cls_cur)
                    CL_SEC, CL_SEI: begin
                        r_d.cc = fu_cc;
                        done   = 1'b1;
                    end
                    CL_STOP: begin
                        // RQ13: timer shutdown and oscillator halt
                        r_d.cc     = fu_cc;
                        r_d.pulse  = '1;
                        r_d.osc_en = 1'b0;
                        r_d.st     = S_STOP;
                    end
                    CL_IRET: begin
                        r_d.k  = 3'd0;
                        r_d.st = S_PULL;
                    end
                    default: done = 1'b1;
                endcase
            end
            S_PAD: begin
                if (r_q.left == 5'd1) begin
                    end_instr = 1'b1;
                end
            end
            S_PULL: begin
                r_d.sp = r_q.sp + 16'd1;
                r_d.k  = r_q.k + 3'd1;
                case (r_q.k)
                    // RQ16: restored mask re-enables interrupts
                    3'd0:    r_d.cc = mem_rdata[4:0];
                    3'd1:    r_d.acc = mem_rdata;
                    3'd2:    r_d.ptr = mem_rdata;
                    3'd3:    r_d.pc[15:8] = mem_rdata;
                    default: r_d.pc[7:0] = mem_rdata;
                endcase
                if (r_q.k == 3'd4) begin
                    done = 1'b1;
                end
            end
            S_PUSH: begin
                r_d.sp = r_q.sp - 16'd1;
                r_d.k  = r_q.k + 3'd1;
                if (r_q.k == 3'd4) begin
                    r_d.cc[`CC_I] = 1'b1;
                    r_d.vec       = IRQ_VECTOR;
                    r_d.st        = S_VHI;
                end
            end
            S_VHI: begin
                r_d.pc[15:8] = mem_rdata;
                r_d.st       = S_VLO;
            end
            S_VLO: begin
                r_d.pc[7:0] = mem_rdata;
                r_d.st      = S_FETCH;
            end
            S_STOP: begin
                // RQ14: low interrupt restarts oscillator
                if (r_q.irq_act) begin
                    r_d.osc_en = 1'b1;
                    r_d.wake   = 12'(WAKE_CYCLES - 1);
                    r_d.st     = S_WAKE;
                end
            end
            S_WAKE: begin
                // RQ14: stabilisation delay, then vector
                if (r_q.wake == 12'h000) begin
                    r_d.k  = 3'd0;
                    r_d.st = S_PUSH;
                end else begin
                    r_d.wake = r_q.wake - 12'h001;
                end
            end
            default: r_d.st = S_FETCH;
        endcase

        // padding keeps the documented cycle count of each variant
        if (done) begin
            if (r_q.left == 5'd1) begin
                end_instr = 1'b1;
            end else begin
                r_d.st = S_PAD;
            end
        end

        // RQ3: masked interrupts wait, program continues
        if (end_instr) begin
            if (r_q.irq_act && !r_d.cc[`CC_I]) begin
                r_d.k  = 3'd0;
                r_d.st = S_PUSH;
            end else begin
                r_d.st = S_FETCH;
            end
        end

        // bus request for the coming cycle, registered
        r_d.req = '0;
        ncls    = decode_class(r_d.op);
        case (r_d.st)
            S_FETCH, S_OPND1, S_OPND2: begin
                r_d.req.addr = r_d.pc;
                r_d.req.re   = 1'b1;
            end
            S_READ: begin
                r_d.req.addr = r_d.ea;
                r_d.req.re   = 1'b1;
            end
            S_WRITE: begin
                r_d.req.addr  = r_d.ea;
                r_d.req.we    = 1'b1;
                // RQ4: accumulator to memory
                // RQ7: pointer to memory
                r_d.req.wdata = (ncls == CL_STX) ? r_d.ptr : r_d.acc;
            end
            S_PUSH: begin
                r_d.req.addr = r_d.sp;
                r_d.req.we   = 1'b1;
                case (r_d.k)
                    3'd0:    r_d.req.wdata = r_d.pc[7:0];
                    3'd1:    r_d.req.wdata = r_d.pc[15:8];
                    3'd2:    r_d.req.wdata = r_d.ptr;
                    3'd3:    r_d.req.wdata = r_d.acc;
                    // RQ17: stacked flags with top ones
                    default: r_d.req.wdata = {`CC_STACK_ONES, r_d.cc};
                endcase
            end
            S_PULL: begin
                r_d.req.addr = r_d.sp + 16'd1;
                r_d.req.re   = 1'b1;
            end
            S_VHI: begin
                r_d.req.addr = r_d.vec;
                r_d.req.re   = 1'b1;
            end
            S_VLO: begin
                r_d.req.addr = r_d.vec + 16'd1;
                r_d.req.re   = 1'b1;
            end
            default: r_d.req = '0;
        endcase
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            r_q          <= '0;
            r_q.st       <= S_VHI;
            r_q.vec      <= RST_VECTOR;
            r_q.req.addr <= RST_VECTOR;
            r_q.req.re   <= 1'b1;
            r_q.acc      <= `ACC_RESET;
            r_q.ptr      <= `PTR_RESET;
            r_q.cc       <= `CC_RESET;
            r_q.sp       <= `SP_RESET;
            r_q.osc_en   <= 1'b1;
            r_q.irq_sync <= 3'b111;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    assign mem_req       = r_q.req;
    assign stop_pulse    = r_q.pulse;
    assign osc_en        = r_q.osc_en;
    assign accumulator   = r_q.acc;
    assign pointer       = r_q.ptr;
    // RQ17: flag order H I N Z C
    assign flag_register = r_q.cc;

endmodule // cpu_set_store_sub_stop_ops

// >>> verif/ops_monitor.sv
`timescale 1ns/1ps
module ops_monitor #(
    parameter int unsigned WAKE_CYCLES = 8
) (
    // clock, reset and interrupt pin
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       ce,
    input wire logic                       irq_n,
    // memory bus
    input wire logic [7:0]                 mem_rdata,
    input wire cpu_slice_pkg::mem_req_t    mem_req,
    // stop control and core state
    input wire cpu_slice_pkg::stop_pulse_t stop_pulse,
    input wire logic                       osc_en,
    input wire logic [7:0]                 accumulator,
    input wire logic [7:0]                 pointer,
    input wire logic [4:0]                 flag_register
);
    import cpu_slice_pkg::*;
    localparam int WLO = WAKE_CYCLES;
    localparam int WHI = WAKE_CYCLES + 2;
    logic data_w;
    // stack pushes land in 007b..007f, everything else is a store
    assign data_w = mem_req.we && !(mem_req.addr inside {[16'h007b:16'h007f]});
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (rst);

    pulse_group_a: assert property (
        stop_pulse.tmr_presc_clr |-> stop_pulse.tmr_irq_dis && stop_pulse.tmr_flag_clr && !osc_en)
        else $error("stop pulses not together");
    pulse_single_a: assert property (
        stop_pulse.tmr_presc_clr |=> !stop_pulse.tmr_presc_clr && !stop_pulse.tmr_flag_clr)
        else $error("stop pulse longer than one cycle");
    stop_entry_a: assert property (
        $fell(osc_en) |-> stop_pulse.tmr_irq_dis && !flag_register[3])
        else $error("oscillator halted without stop or mask kept");
    quiet_stopped_a: assert property (
        !osc_en |-> !mem_req.re && !mem_req.we)
        else $error("bus active while oscillator halted");
    wake_quiet_a: assert property (
        $rose(osc_en) |-> (!mem_req.re && !mem_req.we) [*8])
        else $error("bus active during oscillator settling");
    wake_entry_a: assert property (
        $rose(osc_en) |-> ##[WLO:WHI] mem_req.we)
        else $error("no interrupt entry after settling");
    masked_entry_a: assert property (
        mem_req.we && mem_req.addr == 16'h007f |-> !$past(flag_register[3]))
        else $error("interrupt taken while masked");
    stack_ones_a: assert property (
        mem_req.we && mem_req.addr == 16'h007b |-> mem_req.wdata[7:5] == 3'b111)
        else $error("stacked flags upper bits not ones");
    store_data_a: assert property (
        data_w |-> mem_req.wdata == accumulator || mem_req.wdata == pointer)
        else $error("store data is not a register");
    store_keeps_a: assert property (
        data_w |=> $stable(accumulator) && $stable(pointer))
        else $error("store altered a register");
endmodule // ops_monitor

bind cpu_set_store_sub_stop_ops ops_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) mon (
    .clk(clk), .rst(rst), .ce(ce), .irq_n(irq_n), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .stop_pulse(stop_pulse), .osc_en(osc_en),
    .accumulator(accumulator), .pointer(pointer), .flag_register(flag_register));

// >>> verif/prog_mem.sv
`timescale 1ns/1ps
module prog_mem (
    // clock
    input  wire logic                    clk,
    // bus from the core
    input  wire cpu_slice_pkg::mem_req_t mem_req,
    output logic [7:0]                   mem_rdata
);
    import cpu_slice_pkg::*;
    logic [7:0] ram [0:65535];
    logic [7:0] last_q = 8'h5a;
    // idle bus shows a moving pattern so stale data is never trusted
    assign mem_rdata = mem_req.re ? ram[mem_req.addr] : ~last_q;
    always @(posedge clk) begin
        last_q <= mem_rdata;
        if (mem_req.we) begin
            ram[mem_req.addr] <= mem_req.wdata;
        end
    end
endmodule // prog_mem

// >>> verif/cpu_set_store_sub_stop_ops_tb.sv
`timescale 1ns/1ps
module cpu_set_store_sub_stop_ops_tb;
    import cpu_slice_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        irq_n = 1'b1;
    logic [7:0]  mem_rdata;
    mem_req_t    mem_req;
    stop_pulse_t stop_pulse;
    logic        osc_en;
    logic [7:0]  accumulator;
    logic [7:0]  pointer;
    logic [4:0]  flag_register;
    int          fails = 0;
    int          checks_done = 0;
    int          n;
    logic [7:0]  prog [39] = '{8'h99, 8'h9b, 8'ha0, 8'h01, 8'hb7, 8'h40, 8'hc7, 8'h20, 8'h00,
        8'he7, 8'h10, 8'hd7, 8'h30, 8'h00, 8'hf7, 8'hbf, 8'h41, 8'hcf, 8'h20, 8'h01, 8'hef,
        8'h11, 8'hdf, 8'h30, 8'h01, 8'hff, 8'hb0, 8'h50, 8'hc0, 8'h21, 8'h00, 8'hf0, 8'he0,
        8'h12, 8'hd0, 8'h30, 8'h02, 8'h99, 8'h8e};
    // checkpoints: fetch address, cycles since last, accumulator, flags
    logic [15:0] pt_adr [5] = '{16'h0104, 16'h010f, 16'h011a, 16'h0125, 16'h0126};
    int          pt_cyc [5] = '{6, 24, 24, 19, 2};
    logic [7:0]  pt_acc [5] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
    logic [4:0]  pt_flg [5] = '{5'h0d, 5'h0d, 5'h0b, 5'h0a, 5'h0b};
    logic [15:0] dst [9] = '{16'h0040, 16'h2000, 16'h0010, 16'h3000, 16'h0000,
        16'h0041, 16'h2001, 16'h0011, 16'h3001};
    logic [7:0]  stk [5] = '{8'h27, 8'h01, 8'h00, 8'h00, 8'he3};

    cpu_set_store_sub_stop_ops #(.CMOS(1'b1), .WAKE_CYCLES(8)) DUT (
        .clk(clk), .rst(rst), .ce(1'b1), .irq_n(irq_n), .mem_rdata(mem_rdata),
        .mem_req(mem_req), .stop_pulse(stop_pulse), .osc_en(osc_en),
        .accumulator(accumulator), .pointer(pointer), .flag_register(flag_register));
    prog_mem mem (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // counts cycles until the core reads address a
    task automatic wait_fetch(input logic [15:0] a, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while (!(mem_req.re === 1'b1 && mem_req.addr === a) && cyc < 4000);
    endtask

    initial begin
        for (int a = 0; a < 65536; a++) mem.ram[a] = 8'h00;
        foreach (prog[i]) mem.ram[16'h0100 + i] = prog[i];
        foreach (dst[i]) mem.ram[dst[i]] = 8'h5a;
        {mem.ram[16'hfffe], mem.ram[16'hffff]} = 16'h0100;
        {mem.ram[16'hfffa], mem.ram[16'hfffb]} = 16'h0200;
        {mem.ram[16'h0200], mem.ram[16'h0127]} = 16'h809b;
        {mem.ram[16'h0050], mem.ram[16'h2100]} = 16'h8080;
        {mem.ram[16'h0012], mem.ram[16'h3002]} = 16'h0ff0;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        wait_fetch(16'h0100, n);
        foreach (pt_adr[i]) begin
            wait_fetch(pt_adr[i], n);
            check(16'(n), 16'(pt_cyc[i]));
            check(accumulator, pt_acc[i]);
            check(flag_register, pt_flg[i]);
            check(pointer, 8'h00);
        end
        n = 0;
        while (osc_en !== 1'b0 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        check(stop_pulse, 3'b111);
        check(flag_register, 5'h03);
        repeat (5) @(posedge clk);
        #1 irq_n = 1'b0;
        while (osc_en !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        irq_n = 1'b1;
        wait_fetch(16'h0200, n);
        check(flag_register, 5'h0b);
        foreach (stk[i]) check(mem.ram[16'h007f - i], stk[i]);
        wait_fetch(16'h0127, n);
        check(16'(n), 16'd9);
        check(flag_register, 5'h03);
        wait_fetch(16'h0129, n);
        irq_n = 1'b0;
        wait_fetch(16'h0140, n);
        check(16'(n), 16'd46);
        foreach (dst[i]) check(mem.ram[dst[i]], i < 4 ? 8'hff : 8'h00);
        give_verdict();
    end

    initial begin
        #20000;
        fails++;
        give_verdict();
    end
endmodule // cpu_set_store_sub_stop_ops_tb
